// File: core/carsl_pkg.sv
package carsl_pkg;

  // Register selectors named by instruction operands
  localparam logic [3:0] SEL_FAULT_ADDR  = 4'h0;
  localparam logic [3:0] SEL_PT_BASE     = 4'h1;
  localparam logic [3:0] SEL_SYS_CTRL    = 4'h2;
  localparam logic [3:0] SEL_CODE_SEG    = 4'h3;
  localparam logic [3:0] SEL_EXT_COUNT   = 4'h4;
  localparam logic [3:0] SEL_COUNT_WORD  = 4'h5;
  localparam logic [3:0] SEL_DATA_WORD   = 4'h6;
  localparam logic [3:0] SEL_DATA_HIGH   = 4'h7;
  localparam logic [3:0] SEL_DATA_LOW    = 4'h8;
  localparam logic [3:0] SEL_STR_PTR     = 4'h9;
  localparam logic [3:0] SEL_EXTRA_SEG   = 4'hA;
  localparam logic [3:0] SEL_BP0         = 4'hB;
  localparam logic [3:0] SEL_BP1         = 4'hC;
  localparam logic [3:0] SEL_BP2         = 4'hD;
  localparam logic [3:0] SEL_BP3         = 4'hE;
  localparam logic [3:0] SEL_DBG_SLOT4   = 4'hF;

  localparam int NUM_BP         = 4;
  localparam int PDB_LSB        = 12;
  localparam int PCD_BIT        = 4;
  localparam int PWT_BIT        = 3;
  localparam int PG_BIT         = 31;
  localparam logic [31:0] PTB_KEEP_MASK = 32'hFFFFF018;

  // Breakpoint access types
  localparam logic [1:0] BP_EXEC   = 2'h0;
  localparam logic [1:0] BP_WRITE  = 2'h1;
  localparam logic [1:0] BP_RDWR   = 2'h3;

  typedef struct packed {
    logic        wr;
    logic [3:0]  sel;
    logic [31:0] data;
  } carsl_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [31:0] addr;
  } carsl_access_t;

  typedef struct packed {
    logic        step;
    logic        direction;
  } carsl_string_t;

  typedef enum logic [1:0] {
    CARSL_XFER_NONE = 2'b01,
    CARSL_XFER_LOAD = 2'b10
  } carsl_cs_state_t;

endpackage

// File: core/carsl_bp_match.sv
`timescale 1ns/1ps
module carsl_bp_match (
  input  wire logic [31:0]              bp_addr,
  input  wire logic                     bp_enable,
  input  wire logic [1:0]               bp_type,
  input  wire carsl_pkg::carsl_access_t acc,
  output logic                          hit
);
  import carsl_pkg::*;

  logic type_ok;

  // Pure comparator; the top registers it so hit and exception leave in one stage
  always_comb begin
    unique case (bp_type)
      BP_EXEC:  type_ok = acc.fetch;
      BP_WRITE: type_ok = !acc.fetch && acc.write;
      BP_RDWR:  type_ok = !acc.fetch;
      default:  type_ok = 1'b0;
    endcase
    hit = acc.valid && bp_enable && type_ok && (acc.addr == bp_addr);
  end
endmodule

// File: core/carsl_top.sv
// Operation
// - Paging fault captures the full 32-bit faulting linear address.
// - Bits 31..12 of page table base give directory address high bits.
// - Directory base is page aligned; low 12 address bits are zero.
// - Cache-disable bit drives its pin on unpaged cycles, or always without paging.
// - Write-through bit drives its pin on unpaged cycles, or always without paging.
// - Bits 11..5 and 2..0 of page table base are reserved.
// - Fetch address uses code segment selector with instruction pointer offset.
// - Code segment changes on interrupts, exceptions and far transfers.
// - String pointer steps up or down per element by direction flag.
// - String destination addresses use only the extra segment.
// - High data byte shares bits 15..8 of data word.
// - Low data byte shares bits 7..0 of data word.
// - Count word is the low half of extended count.
// - Four independent 32-bit breakpoint address registers.
// - Enabled breakpoint match with chosen access type raises debug exception.
// - Instruction-fetch and data breakpoints are both supported.
// - Paging is enabled while system control bit 31 is one.
// - Two-bit type selects execute, write only, or read-write.
`timescale 1ns/1ps
module carsl_top (
  input  wire logic                      CLK_SYS,
  input  wire logic                      SYS_RST,
  input  wire carsl_pkg::carsl_reg_req_t REG_REQ,
  input  wire carsl_pkg::carsl_access_t  ACCESS,
  input  wire logic                      PAGE_FAULT,
  input  wire logic                      BUS_CYCLE_PAGED,
  input  wire logic                      CS_LOAD,
  input  wire logic [15:0]               CS_LOAD_VALUE,
  input  wire logic [31:0]               INSTR_PTR,
  input  wire logic                      SHORT_MODE,
  input  wire carsl_pkg::carsl_string_t  STRING_OP,
  input  wire logic [3:0]                BP_ENABLE,
  input  wire logic [7:0]                BP_TYPE,
  output logic [31:0]                    REG_RDATA,
  output logic                           PAGE_CACHE_DISABLE,
  output logic                           PAGE_WRITE_THROUGH,
  output logic [31:0]                    PAGE_DIRECTORY_BASE,
  output logic                           PAGING_ENABLE,
  output logic [15:0]                    FETCH_SEGMENT,
  output logic [31:0]                    FETCH_OFFSET,
  output logic [15:0]                    DEST_SEGMENT,
  output logic [15:0]                    DEST_OFFSET,
  output logic                           DEBUG_EXCEPTION,
  output logic [3:0]                     BP_HIT
);
  import carsl_pkg::*;

  logic [31:0] fault_linear_address;
  logic [31:0] page_table_base_control;
  logic [31:0] system_control;
  logic [15:0] code_segment_selector;
  logic [31:0] extended_count;
  logic [15:0] data_word;
  logic [15:0] string_target_pointer;
  logic [15:0] extra_segment;
  logic [31:0] bp_addr [NUM_BP];
  logic [31:0] debug_slot_four;
  carsl_cs_state_t cs_state;

  logic [31:0] next_fault_linear_address;
  logic [31:0] next_page_table_base_control;
  logic [31:0] next_system_control;
  logic [15:0] next_code_segment_selector;
  logic [31:0] next_extended_count;
  logic [15:0] next_data_word;
  logic [15:0] next_string_target_pointer;
  logic [15:0] next_extra_segment;
  logic [31:0] next_bp_addr [NUM_BP];
  logic [31:0] next_debug_slot_four;
  carsl_cs_state_t next_cs_state;
  logic [31:0] next_rdata;
  logic        next_pcd;
  logic        next_pwt;
  logic        paging_on;
  logic [3:0]  hit;

  assign paging_on = system_control[PG_BIT];

  always_comb begin
    next_fault_linear_address    = fault_linear_address;
    next_page_table_base_control = page_table_base_control;
    next_system_control          = system_control;
    next_extended_count          = extended_count;
    next_data_word               = data_word;
    next_string_target_pointer   = string_target_pointer;
    next_extra_segment           = extra_segment;
    next_debug_slot_four         = debug_slot_four;
    for (int i = 0; i < NUM_BP; i++) begin
      next_bp_addr[i] = bp_addr[i];
    end
    if (REG_REQ.wr) begin
      unique case (REG_REQ.sel)
        SEL_FAULT_ADDR: next_fault_linear_address = REG_REQ.data;
        // Reserved bits are stored as zero so reads are deterministic
        SEL_PT_BASE:    next_page_table_base_control = REG_REQ.data & PTB_KEEP_MASK;
        SEL_SYS_CTRL:   next_system_control = REG_REQ.data;
        SEL_EXT_COUNT:  next_extended_count = REG_REQ.data;
        SEL_COUNT_WORD: next_extended_count[15:0] = REG_REQ.data[15:0];
        SEL_DATA_WORD:  next_data_word = REG_REQ.data[15:0];
        SEL_DATA_HIGH:  next_data_word[15:8] = REG_REQ.data[7:0];
        SEL_DATA_LOW:   next_data_word[7:0] = REG_REQ.data[7:0];
        SEL_STR_PTR:    next_string_target_pointer = REG_REQ.data[15:0];
        SEL_EXTRA_SEG:  next_extra_segment = REG_REQ.data[15:0];
        SEL_BP0:        next_bp_addr[0] = REG_REQ.data;
        SEL_BP1:        next_bp_addr[1] = REG_REQ.data;
        SEL_BP2:        next_bp_addr[2] = REG_REQ.data;
        SEL_BP3:        next_bp_addr[3] = REG_REQ.data;
        SEL_DBG_SLOT4:  next_debug_slot_four = REG_REQ.data;
        default:        ;
      endcase
    end
    // Hardware fault capture wins over a software write in the same cycle
    if (PAGE_FAULT) begin
      next_fault_linear_address = ACCESS.addr;
    end
    // A string step wins over a same-cycle software write of the pointer
    if (STRING_OP.step) begin
      if (STRING_OP.direction) begin
        next_string_target_pointer = string_target_pointer - 16'h0001;
      end else begin
        next_string_target_pointer = string_target_pointer + 16'h0001;
      end
    end
  end

  // Control transfers load the selector; a software write is the other path
  always_comb begin
    next_code_segment_selector = code_segment_selector;
    next_cs_state              = CARSL_XFER_NONE;
    if (REG_REQ.wr && REG_REQ.sel == SEL_CODE_SEG) begin
      next_code_segment_selector = REG_REQ.data[15:0];
    end
    if (CS_LOAD) begin
      next_code_segment_selector = CS_LOAD_VALUE;
      next_cs_state              = CARSL_XFER_LOAD;
    end
  end

  always_comb begin
    unique case (REG_REQ.sel)
      SEL_FAULT_ADDR: next_rdata = fault_linear_address;
      SEL_PT_BASE:    next_rdata = page_table_base_control;
      SEL_SYS_CTRL:   next_rdata = system_control;
      SEL_CODE_SEG:   next_rdata = {16'h0000, code_segment_selector};
      SEL_EXT_COUNT:  next_rdata = extended_count;
      SEL_COUNT_WORD: next_rdata = {16'h0000, extended_count[15:0]};
      SEL_DATA_WORD:  next_rdata = {16'h0000, data_word};
      SEL_DATA_HIGH:  next_rdata = {24'h000000, data_word[15:8]};
      SEL_DATA_LOW:   next_rdata = {24'h000000, data_word[7:0]};
      SEL_STR_PTR:    next_rdata = {16'h0000, string_target_pointer};
      SEL_EXTRA_SEG:  next_rdata = {16'h0000, extra_segment};
      SEL_BP0:        next_rdata = bp_addr[0];
      SEL_BP1:        next_rdata = bp_addr[1];
      SEL_BP2:        next_rdata = bp_addr[2];
      SEL_BP3:        next_rdata = bp_addr[3];
      SEL_DBG_SLOT4:  next_rdata = debug_slot_four;
      default:        next_rdata = 32'h00000000;
    endcase
  end

  // Pin follows the register on unpaged cycles, or always when paging is off
  always_comb begin
    next_pcd = PAGE_CACHE_DISABLE;
    next_pwt = PAGE_WRITE_THROUGH;
    if (!paging_on || !BUS_CYCLE_PAGED) begin
      next_pcd = page_table_base_control[PCD_BIT];
      next_pwt = page_table_base_control[PWT_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_BP; g++) begin : gen_bp
      carsl_bp_match u_match (
        .bp_addr   (bp_addr[g]),
        .bp_enable (BP_ENABLE[g]),
        .bp_type   (BP_TYPE[2*g +: 2]),
        .acc       (ACCESS),
        .hit       (hit[g])
      );
    end
  endgenerate

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fault_linear_address    <= 32'h00000000;
      page_table_base_control <= 32'h00000000;
      system_control          <= 32'h00000000;
      code_segment_selector   <= 16'h0000;
      extended_count          <= 32'h00000000;
      data_word               <= 16'h0000;
      string_target_pointer   <= 16'h0000;
      extra_segment           <= 16'h0000;
      debug_slot_four         <= 32'h00000000;
      cs_state                <= CARSL_XFER_NONE;
      for (int i = 0; i < NUM_BP; i++) begin
        bp_addr[i] <= 32'h00000000;
      end
      REG_RDATA           <= 32'h00000000;
      PAGE_CACHE_DISABLE  <= 1'b0;
      PAGE_WRITE_THROUGH  <= 1'b0;
      PAGE_DIRECTORY_BASE <= 32'h00000000;
      PAGING_ENABLE       <= 1'b0;
      FETCH_SEGMENT       <= 16'h0000;
      FETCH_OFFSET        <= 32'h00000000;
      DEST_SEGMENT        <= 16'h0000;
      DEST_OFFSET         <= 16'h0000;
      BP_HIT              <= 4'h0;
      DEBUG_EXCEPTION     <= 1'b0;
    end else begin
      fault_linear_address    <= next_fault_linear_address;
      page_table_base_control <= next_page_table_base_control;
      system_control          <= next_system_control;
      code_segment_selector   <= next_code_segment_selector;
      extended_count          <= next_extended_count;
      data_word               <= next_data_word;
      string_target_pointer   <= next_string_target_pointer;
      extra_segment           <= next_extra_segment;
      debug_slot_four         <= next_debug_slot_four;
      cs_state                <= next_cs_state;
      for (int i = 0; i < NUM_BP; i++) begin
        bp_addr[i] <= next_bp_addr[i];
      end
      REG_RDATA           <= next_rdata;
      PAGE_CACHE_DISABLE  <= next_pcd;
      PAGE_WRITE_THROUGH  <= next_pwt;
      PAGE_DIRECTORY_BASE <= {page_table_base_control[31:PDB_LSB], 12'h000};
      PAGING_ENABLE       <= paging_on;
      FETCH_SEGMENT       <= code_segment_selector;
      FETCH_OFFSET        <= SHORT_MODE ? {16'h0000, INSTR_PTR[15:0]} : INSTR_PTR;
      DEST_SEGMENT        <= extra_segment;
      DEST_OFFSET         <= string_target_pointer;
      // Both taken from one comparator stage; slot four has no comparator at all
      BP_HIT              <= hit;
      DEBUG_EXCEPTION     <= |hit;
    end
  end

endmodule

// File: test/carsl_top_sva.sv
`timescale 1ns/1ps
module carsl_top_sva
  import carsl_pkg::*;
(
  input wire logic                      CLK_SYS,
  input wire logic                      SYS_RST,
  input wire carsl_pkg::carsl_reg_req_t REG_REQ,
  input wire carsl_pkg::carsl_access_t  ACCESS,
  input wire logic                      CS_LOAD,
  input wire logic [15:0]               CS_LOAD_VALUE,
  input wire logic [31:0]               INSTR_PTR,
  input wire logic                      SHORT_MODE,
  input wire logic [3:0]                BP_ENABLE,
  input wire logic [7:0]                BP_TYPE,
  input wire logic [31:0]               PAGE_DIRECTORY_BASE,
  input wire logic                      PAGING_ENABLE,
  input wire logic [15:0]               FETCH_SEGMENT,
  input wire logic [31:0]               FETCH_OFFSET,
  input wire logic                      DEBUG_EXCEPTION,
  input wire logic [3:0]                BP_HIT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_pt_wr;
    REG_REQ.wr && REG_REQ.sel == SEL_PT_BASE;
  endsequence
  sequence s_sc_wr;
    REG_REQ.wr && REG_REQ.sel == SEL_SYS_CTRL;
  endsequence
  // Local copy, since the selector may be reloaded before the copy lands
  property p_cs;
    logic [15:0] v;
    (CS_LOAD, v = CS_LOAD_VALUE) |-> ##2 FETCH_SEGMENT == v;
  endproperty
  AST_PDB_ALIGN: assert property (PAGE_DIRECTORY_BASE[11:0] == 12'h000)
    else $error("directory base not page aligned");
  AST_PDB_LOAD: assert property (s_pt_wr |-> ##2 PAGE_DIRECTORY_BASE == ($past(REG_REQ.data, 2) & 32'hFFFFF000))
    else $error("directory base wrong after write");
  AST_PG_LOAD: assert property (s_sc_wr |-> ##2 PAGING_ENABLE == $past(REG_REQ.data[PG_BIT], 2))
    else $error("paging enable wrong after write");
  AST_CS_LOAD: assert property (p_cs)
    else $error("code segment not loaded");
  AST_FETCH_OFF: assert property (!SHORT_MODE |=> FETCH_OFFSET == $past(INSTR_PTR))
    else $error("fetch offset wrong");
  AST_DBG_OR: assert property (DEBUG_EXCEPTION == (|BP_HIT))
    else $error("debug exception not the OR of hits");
  AST_HIT_CAUSE: assert property (BP_HIT != 4'h0 |-> $past(ACCESS.valid) && (BP_HIT & ~$past(BP_ENABLE)) == 4'h0)
    else $error("hit without enabled access");
  AST_EXEC_DATA: assert property (ACCESS.valid && !ACCESS.fetch && BP_TYPE[1:0] == BP_EXEC |=> !BP_HIT[0])
    else $error("execute breakpoint hit by data access");
  AST_TYPE_NEVER: assert property (ACCESS.valid && BP_TYPE[3:2] == 2'h2 |=> !BP_HIT[1])
    else $error("unused type triggered");
endmodule

// File: test/tb_carsl_top.sv
`timescale 1ns/1ps
module tb_carsl_top;
  import carsl_pkg::*;
  logic           clk_sys = 1'b0;
  logic           sys_rst = 1'b1;
  carsl_reg_req_t req = '0;
  carsl_access_t  acc = '0;
  carsl_string_t  str = '0;
  logic           fault = 1'b0, paged = 1'b0, cs_ld = 1'b0, sm = 1'b0, page_cache_disable, page_write_through, pg, dbg, e, x;
  logic [15:0]    cs_val = 16'h0000, fseg, dseg, doff;
  logic [31:0]    ip = 32'h00000000, rdata, pdb, foff;
  logic [3:0]     bp_en = 4'h0, hit, h;
  logic [7:0]     bp_ty = 8'h00;
  logic [31:0]    m [16];
  logic [1:0]     pins = 2'h0;
  int             bad_count = 0, total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  carsl_top dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_REQ(req), .ACCESS(acc), .PAGE_FAULT(fault),
    .BUS_CYCLE_PAGED(paged), .CS_LOAD(cs_ld), .CS_LOAD_VALUE(cs_val), .INSTR_PTR(ip), .SHORT_MODE(sm),
    .STRING_OP(str), .BP_ENABLE(bp_en), .BP_TYPE(bp_ty), .REG_RDATA(rdata), .PAGE_CACHE_DISABLE(page_cache_disable),
    .PAGE_WRITE_THROUGH(page_write_through), .PAGE_DIRECTORY_BASE(pdb), .PAGING_ENABLE(pg), .FETCH_SEGMENT(fseg),
    .FETCH_OFFSET(foff), .DEST_SEGMENT(dseg), .DEST_OFFSET(doff), .DEBUG_EXCEPTION(dbg), .BP_HIT(hit));
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] ex(input logic [3:0] s);
    case (s)
      SEL_COUNT_WORD: return {16'h0000, m[4][15:0]};
      SEL_DATA_HIGH: return {24'h000000, m[6][15:8]};
      SEL_DATA_LOW: return {24'h000000, m[6][7:0]};
      SEL_PT_BASE: return m[1] & PTB_KEEP_MASK;
      SEL_CODE_SEG, SEL_STR_PTR, SEL_EXTRA_SEG, SEL_DATA_WORD: return {16'h0000, m[s][15:0]};
      default: return m[s];
    endcase
  endfunction
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    req = '{1'b1, s, d};
    @(negedge clk_sys);
    req.wr = 1'b0;
    @(negedge clk_sys);
    case (s)
      SEL_COUNT_WORD: m[4][15:0] = d[15:0];
      SEL_DATA_HIGH: m[6][15:8] = d[7:0];
      SEL_DATA_LOW: m[6][7:0] = d[7:0];
      default: m[s] = d;
    endcase
    // Pins follow the register on cycles that are not paged, or always when paging is off
    if (!(paged && m[SEL_SYS_CTRL][PG_BIT])) pins = m[SEL_PT_BASE][4:3];
  endtask
  task automatic rdall;
    for (int s = 0; s < 15; s++) begin
      req.sel = 4'(s);
      repeat (2) @(negedge clk_sys);
      chk(rdata, ex(4'(s)));
    end
    chk(pdb, m[1] & 32'hFFFFF000);
    chk({30'h0, page_cache_disable, page_write_through}, {30'h0, pins});
    chk({31'h0, pg}, {31'h0, m[2][PG_BIT]});
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim;
  end
  initial begin
    void'($urandom(34989));
    foreach (m[i]) m[i] = 32'h00000000;
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    rdall;
    repeat (30) begin
      paged = 1'($urandom);
      wr(4'($urandom), $urandom);
      rdall;
    end
    paged = 1'b1;
    wr(SEL_SYS_CTRL, 32'h80000000);
    wr(SEL_PT_BASE, 32'hFFFFFFFF ^ {27'h0, pins, 3'h0});
    rdall;
    paged = 1'b0;
    pins = m[1][4:3];
    rdall;
    for (int s = 10; s < 16; s++) wr(4'(s), $urandom);
    repeat (20) begin
      acc.addr = $urandom;
      cs_val = 16'($urandom);
      ip = $urandom;
      sm = 1'($urandom);
      str = '{1'b1, 1'($urandom)};
      fault = 1'b1;
      cs_ld = 1'b1;
      @(negedge clk_sys);
      {fault, cs_ld, str.step} = 3'h0;
      m[0] = acc.addr;
      m[3] = {16'h0000, cs_val};
      m[9][15:0] = str.direction ? m[9][15:0] - 16'h0001 : m[9][15:0] + 16'h0001;
      repeat (2) @(negedge clk_sys);
      chk({16'h0000, fseg}, m[3]);
      chk(foff, sm ? {16'h0000, ip[15:0]} : ip);
      chk({16'h0000, doff}, {16'h0000, m[9][15:0]});
      chk({16'h0000, dseg}, {16'h0000, m[10][15:0]});
      rdall;
    end
    for (int n = 0; n < 4; n++)
      for (int t = 0; t < 4; t++)
        for (int k = 0; k < 3; k++) begin
          e = 1'($urandom);
          x = 1'($urandom);
          bp_en = 4'(e) << n;
          bp_ty = 8'(t) << (2 * n);
          acc = '{1'b1, k == 0, k == 1, m[11 + n] ^ {31'h0, x}};
          @(negedge clk_sys);
          acc.valid = 1'b0;
          h = (((t == 0 && k == 0) || (t == 1 && k == 1) || (t == 3 && k > 0)) && e && !x) ? 4'h1 << n : 4'h0;
          chk({28'h0, hit}, {28'h0, h});
          chk({31'h0, dbg}, {31'h0, |h});
          @(negedge clk_sys);
        end
    end_sim;
  end
endmodule
bind carsl_top carsl_top_sva u_sva (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REG_REQ(REG_REQ), .ACCESS(ACCESS),
  .CS_LOAD(CS_LOAD), .CS_LOAD_VALUE(CS_LOAD_VALUE), .INSTR_PTR(INSTR_PTR), .SHORT_MODE(SHORT_MODE),
  .BP_ENABLE(BP_ENABLE), .BP_TYPE(BP_TYPE), .PAGE_DIRECTORY_BASE(PAGE_DIRECTORY_BASE), .PAGING_ENABLE(PAGING_ENABLE),
  .FETCH_SEGMENT(FETCH_SEGMENT), .FETCH_OFFSET(FETCH_OFFSET), .DEBUG_EXCEPTION(DEBUG_EXCEPTION), .BP_HIT(BP_HIT));
